// ---- fourteen_bit_instruction_decode.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Each instruction is one 14-bit word: opcode plus operand fields.
// - Every instruction is byte-class, bit-class or literal/control.
// - Byte ops use a register-address field and a one-bit destination.
// - Destination 0 writes the accumulator, 1 writes the file register.
// - Register address is a 7-bit field, 0x00 to 0x7F in the bank.
// - Bit ops pick one bit of the addressed 8-bit register.
// - Literal ops take an 8-bit data or 11-bit jump target.
// - Don't-care bits never change which instruction executes.
// - One instruction cycle is four oscillator periods.
// - Skip taken or PC change costs two cycles; second is a NOP.
// - File register instructions read, modify, then store the result.
// - The register is read even when the instruction only writes it.
// - Clearing the second port reads it, clearing the change mismatch.
module fourteen_bit_instruction_decode
   import fourteen_bit_pkg::*;
#(
   parameter logic [FADDR_W-1:0] PORT_ADDR = 7'h06
)(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Program memory
   output logic [PC_W-1:0] prog_addr_o,
   input wire logic [INSTR_W-1:0] instr_i,
   // File register access
   output logic [FADDR_W-1:0] file_addr_o,
   output logic file_rd_o,
   input wire logic [DATA_W-1:0] file_rdata_i,
   output logic file_wr_o,
   output logic [DATA_W-1:0] file_wdata_o,
   output logic second_io_port_rd_o,
   // Core state
   output logic [DATA_W-1:0] w_o,
   output logic carry_o,
   output logic digit_carry_o,
   output logic zero_o,
   output logic [PHASE_W-1:0] phase_o,
   output logic cycle_start_o,
   output logic nop_cycle_o,
   // Control events
   output logic clrwdt_o,
   output logic sleep_o,
   output logic retfie_o,
   output logic illegal_o
);

   logic [PHASE_W-1:0] phase_q, phase_d;
   logic [INSTR_W-1:0] ir_q, ir_d;
   logic flush_q, flush_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic [SP_W-1:0] sp_q, sp_d;
   logic [PC_W-1:0] stack_q [STACK_DEPTH];
   logic [DATA_W-1:0] opnd_q, opnd_d, res_q, res_d, w_q, w_d;
   logic cn_q, cn_d, dcn_q, dcn_d, skip_q, skip_d;
   logic c_q, c_d, dc_q, dc_d, z_q, z_d;
   iclass_t cls;
   op_t op;
   logic [FADDR_W-1:0] faddr;
   logic [BIT_W-1:0] bitsel;
   logic [LIT8_W-1:0] lit8;
   logic [LIT11_W-1:0] lit11;
   dest_t dest;
   logic [DATA_W-1:0] alu_res, alu_a, alu_b, bmask;
   logic alu_c, alu_dc, alu_skip, alu_cin, dbit, live, stack_we;
   logic [DATA_W:0] sum;
   logic [NIB_W:0] nsum;

   // Whole 14-bit word held and decoded
   instr_field_decode u_decode (
      .instr_i(ir_q),
      .class_o(cls),
      .op_o(op),
      .faddr_o(faddr),
      .dbit_o(dbit),
      .bitsel_o(bitsel),
      .lit8_o(lit8),
      .lit11_o(lit11)
   );

   assign dest = dest_of(op, cls, dbit);
   assign live = !flush_q;

   // Modify step: operand from the read, accumulator, literal or carry
   always_comb begin
      alu_a = (cls == CLS_LIT) ? lit8 : opnd_q;
      alu_b = w_q;
      alu_cin = 1'b0;
      if (op inside {OP_SUBWF, OP_SUBLW}) begin
         alu_b = ~w_q;
         alu_cin = 1'b1;
      end
      sum = {1'b0, alu_a} + {1'b0, alu_b} + {{DATA_W{1'b0}}, alu_cin};
      nsum = {1'b0, alu_a[NIB_W-1:0]} + {1'b0, alu_b[NIB_W-1:0]} +
             {{NIB_W{1'b0}}, alu_cin};
      // One-hot mask from the bit-select field
      bmask = DATA_ONE << bitsel;
      alu_res = sum[DATA_W-1:0];
      alu_c = sum[DATA_W];
      alu_dc = nsum[NIB_W];
      alu_skip = 1'b0;
      case (op)
         OP_ANDWF, OP_ANDLW: alu_res = alu_a & w_q;
         OP_IORWF, OP_IORLW: alu_res = alu_a | w_q;
         OP_XORWF, OP_XORLW: alu_res = alu_a ^ w_q;
         OP_CLEAR_REGISTER_INSTR, OP_CLRW: alu_res = DATA_ZERO;
         OP_COMF: alu_res = ~opnd_q;
         OP_DECF, OP_DECFSZ: alu_res = opnd_q - DATA_ONE;
         OP_INCF, OP_INCFSZ: alu_res = opnd_q + DATA_ONE;
         OP_MOVF: alu_res = opnd_q;
         OP_MOVWF: alu_res = w_q;
         OP_MOVLW, OP_RETLW: alu_res = lit8;
         OP_RLF: {alu_c, alu_res} = {opnd_q, c_q};
         OP_RRF: {alu_res, alu_c} = {c_q, opnd_q};
         OP_SWAPF: alu_res = {opnd_q[NIB_W-1:0], opnd_q[DATA_W-1:NIB_W]};
         OP_BCF: alu_res = opnd_q & ~bmask;
         OP_BSF: alu_res = opnd_q | bmask;
         OP_BTFSC: alu_res = opnd_q;
         OP_BTFSS: alu_res = opnd_q;
         default: alu_res = sum[DATA_W-1:0];
      endcase
      if (op inside {OP_DECFSZ, OP_INCFSZ}) begin
         alu_skip = (alu_res == DATA_ZERO);
      end else if (op == OP_BTFSC) begin
         alu_skip = ((opnd_q & bmask) == DATA_ZERO);
      end else if (op == OP_BTFSS) begin
         alu_skip = ((opnd_q & bmask) != DATA_ZERO);
      end
   end

   // Sequencer and datapath next state, one phase per clock
   always_comb begin
      phase_d = (phase_q == PH_Q4) ? PH_Q1 : phase_q + PH_STEP;
      ir_d = ir_q;
      flush_d = flush_q;
      pc_d = pc_q;
      sp_d = sp_q;
      stack_we = 1'b0;
      opnd_d = opnd_q;
      res_d = res_q;
      cn_d = cn_q;
      dcn_d = dcn_q;
      skip_d = skip_q;
      w_d = w_q;
      c_d = c_q;
      dc_d = dc_q;
      z_d = z_q;
      unique case (phase_q)
         PH_Q1: begin
         end
         PH_Q2: begin
            if (live && file_op(op, cls)) begin
               opnd_d = file_rdata_i;
            end
         end
         PH_Q3: begin
            if (live) begin
               res_d = alu_res;
               cn_d = alu_c;
               dcn_d = alu_dc;
               skip_d = alu_skip;
            end
         end
         PH_Q4: begin
            // Prefetch of the next word overlaps this execute
            ir_d = instr_i;
            pc_d = pc_q + PC_STEP;
            flush_d = 1'b0;
            if (live) begin
               // Accumulator result when destination is W
               if (dest == DST_W) begin
                  w_d = res_q;
               end
               if (op inside {OP_ADDWF, OP_ANDWF, OP_CLRW, OP_COMF,
                     OP_CLEAR_REGISTER_INSTR, OP_DECF, OP_INCF, OP_IORWF,
                     OP_MOVF, OP_SUBWF, OP_XORWF, OP_ADDLW, OP_ANDLW,
                     OP_IORLW, OP_SUBLW, OP_XORLW}) begin
                  z_d = (res_q == DATA_ZERO);
               end
               if (op inside {OP_ADDWF, OP_SUBWF, OP_ADDLW, OP_SUBLW}) begin
                  c_d = cn_q;
                  dc_d = dcn_q;
               end
               if (op inside {OP_RLF, OP_RRF}) begin
                  c_d = cn_q;
               end
               // Taken skip or PC change discards the prefetch
               if (op inside {OP_GOTO, OP_CALL}) begin
                  // 11-bit target within the current page
                  pc_d = {pc_q[PC_W-1:LIT11_W], lit11};
                  flush_d = 1'b1;
                  stack_we = (op == OP_CALL);
                  sp_d = (op == OP_CALL) ? sp_q + SP_STEP : sp_q;
               end else if (op inside {OP_RETURN, OP_RETLW, OP_RETFIE}) begin
                  pc_d = stack_q[sp_q - SP_STEP];
                  sp_d = sp_q - SP_STEP;
                  flush_d = 1'b1;
               end else if (skip_q) begin
                  flush_d = 1'b1;
               end
            end
         end
      endcase
   end

   // Registers; the return stack is plain storage with no reset
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         phase_q <= PH_Q1;
         ir_q <= NOP_WORD;
         flush_q <= 1'b1;
         pc_q <= PC_RESET;
         sp_q <= SP_RESET;
         opnd_q <= DATA_ZERO;
         res_q <= DATA_ZERO;
         cn_q <= 1'b0;
         dcn_q <= 1'b0;
         skip_q <= 1'b0;
         w_q <= DATA_ZERO;
         c_q <= 1'b0;
         dc_q <= 1'b0;
         z_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         ir_q <= ir_d;
         flush_q <= flush_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         opnd_q <= opnd_d;
         res_q <= res_d;
         cn_q <= cn_d;
         dcn_q <= dcn_d;
         skip_q <= skip_d;
         w_q <= w_d;
         c_q <= c_d;
         dc_q <= dc_d;
         z_q <= z_d;
      end
      if (stack_we) begin
         stack_q[sp_q] <= pc_q;
      end
   end

   // 7-bit register address straight from the word
   assign file_addr_o = faddr;
   // Read strobe for every file instruction, write-only ones too
   assign file_rd_o = live && (phase_q == PH_Q2) && file_op(op, cls);
   // Store step steered by the destination bit
   assign file_wr_o = live && (phase_q == PH_Q4) && (dest == DST_F);
   assign file_wdata_o = res_q;
   // Port sees its own read, which clears its change mismatch
   assign second_io_port_rd_o = file_rd_o && (faddr == PORT_ADDR);

   // Status and sequencing outputs
   assign prog_addr_o = pc_q;
   assign w_o = w_q;
   assign carry_o = c_q;
   assign digit_carry_o = dc_q;
   assign zero_o = z_q;
   assign phase_o = phase_q;
   // Cycle marker once every four clocks
   assign cycle_start_o = (phase_q == PH_Q1);
   assign nop_cycle_o = flush_q;
   assign clrwdt_o = live && (phase_q == PH_Q4) && (op == OP_CLRWDT);
   assign sleep_o = live && (phase_q == PH_Q4) && (op == OP_SLEEP);
   assign retfie_o = live && (phase_q == PH_Q4) && (op == OP_RETFIE);
   assign illegal_o = live && (phase_q == PH_Q4) && (op == OP_ILLEGAL);

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   a_cycle_four_clocks: assert property (
      cycle_start_o |=> !cycle_start_o [*3] ##1 cycle_start_o)
      else $error("instruction cycle is not four clocks");
   // Store follows read of same register
   a_rmw_read_first: assert property (
      file_wr_o |-> $past(file_rd_o, 2) && $stable(file_addr_o))
      else $error("file write without earlier read");
   a_clear_reads_reg: assert property (
      (live && phase_q == PH_Q2 && op == OP_CLEAR_REGISTER_INSTR) |->
      file_rd_o ##2 (file_wr_o && file_wdata_o == DATA_ZERO))
      else $error("clear did not read then write zero");
   a_port_read_strobe: assert property (
      second_io_port_rd_o ==
      (file_rd_o && ir_q[F_LSB +: FADDR_W] == PORT_ADDR))
      else $error("port read strobe does not match port read");
   a_dest_accum: assert property (
      (live && phase_q == PH_Q4 && cls == CLS_BYTE && !dbit &&
       file_op(op, cls)) |-> !file_wr_o ##1 (w_q == $past(res_q)))
      else $error("d=0 result not placed in accumulator");
   a_dest_file: assert property (
      (live && phase_q == PH_Q4 && cls == CLS_BYTE && dbit &&
       op != OP_NOP) |-> file_wr_o && file_addr_o == ir_q[F_LSB +: FADDR_W])
      else $error("d=1 result not stored to file");
   // Jump costs one extra NOP cycle
   a_jump_two_cycles: assert property (
      (live && phase_q == PH_Q4 && op == OP_GOTO) |=>
      nop_cycle_o [*4] ##1 !nop_cycle_o)
      else $error("jump did not run exactly one NOP cycle");
   a_jump_target: assert property (
      (live && phase_q == PH_Q4 && op == OP_GOTO) |=>
      prog_addr_o[LIT11_W-1:0] == $past(lit11))
      else $error("jump target not taken from literal");
   a_bit_set_sel: assert property (
      (live && phase_q == PH_Q4 && op == OP_BSF) |->
      file_wr_o && file_wdata_o[bitsel])
      else $error("bit set missed the selected bit");
   a_dont_care_bits: assert property (
      (ir_q & CLRW_MASK) == CLRW_WORD |-> op == OP_CLRW)
      else $error("don't-care bits changed decode");
   a_bit_class: assert property (
      ir_q[CLS_LSB +: CLS_W] == BIT_CLS_CODE |-> cls == CLS_BIT)
      else $error("bit-class word misclassified");

   c_jump: cover property (live && phase_q == PH_Q4 && op == OP_GOTO);
   c_skip_taken: cover property (live && phase_q == PH_Q4 && skip_q);
   c_port_clear: cover property (
      second_io_port_rd_o && op == OP_CLEAR_REGISTER_INSTR);
   c_return: cover property (live && phase_q == PH_Q4 && op == OP_RETURN);

endmodule

// ---- fourteen_bit_pkg.sv ----
package fourteen_bit_pkg;

   // Word and field widths
   localparam int INSTR_W = 14;
   localparam int FADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int DATA_W = 8;
   localparam int NIB_W = 4;
   localparam int LIT8_W = 8;
   localparam int LIT11_W = 11;
   localparam int PC_W = 13;
   localparam int SP_W = 3;
   localparam int STACK_DEPTH = 8;
   localparam int CLS_W = 2;

   // Field positions within the instruction word
   localparam int F_LSB = 0;
   localparam int D_POS = 7;
   localparam int B_LSB = 7;
   localparam int K_LSB = 0;
   localparam int CLS_LSB = 12;
   localparam logic [CLS_W-1:0] BIT_CLS_CODE = 2'h1;

   // Don't-care encodings; only the CLRW pair is used by the checks
   localparam logic [INSTR_W-1:0] CLRW_MASK = 14'h3F80;
   localparam logic [INSTR_W-1:0] CLRW_WORD = 14'h0100;
   localparam logic [INSTR_W-1:0] NOP_MASK = 14'h3F9F;
   localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;

   // Timing: one instruction cycle is four oscillator periods
   localparam int OSC_PERIOD_NS = 50;
   localparam int INSTR_CYCLE_NS = 4 * OSC_PERIOD_NS;
   localparam int PHASES = INSTR_CYCLE_NS / OSC_PERIOD_NS;
   localparam int PHASE_W = 2;
   localparam logic [PHASE_W-1:0] PH_Q1 = 2'h0;
   localparam logic [PHASE_W-1:0] PH_Q2 = 2'h1;
   localparam logic [PHASE_W-1:0] PH_Q3 = 2'h2;
   localparam logic [PHASE_W-1:0] PH_Q4 = 2'(PHASES - 1);
   localparam logic [PHASE_W-1:0] PH_STEP = 2'h1;

   // Reset and data constants
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
   localparam logic [SP_W-1:0] SP_RESET = 3'h0;
   localparam logic [SP_W-1:0] SP_STEP = 3'h1;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;

   typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_LIT} iclass_t;
   typedef enum logic [1:0] {DST_NONE, DST_W, DST_F} dest_t;

   typedef enum logic [5:0] {
      OP_ADDWF, OP_ANDWF, OP_CLEAR_REGISTER_INSTR, OP_CLRW, OP_COMF, OP_DECF,
      OP_DECFSZ, OP_INCF, OP_INCFSZ, OP_IORWF, OP_MOVF, OP_MOVWF,
      OP_NOP, OP_RLF, OP_RRF, OP_SUBWF, OP_SWAPF, OP_XORWF,
      OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS,
      OP_ADDLW, OP_ANDLW, OP_CALL, OP_CLRWDT, OP_GOTO, OP_IORLW,
      OP_MOVLW, OP_RETFIE, OP_RETLW, OP_RETURN, OP_SLEEP, OP_SUBLW,
      OP_XORLW, OP_ILLEGAL
   } op_t;

   // True for instructions that name a file register
   function automatic logic file_op(input op_t op, input iclass_t cls);
      return (cls == CLS_BIT) ||
             ((cls == CLS_BYTE) && !(op inside {OP_NOP, OP_CLRW}));
   endfunction

   // Where the result lands
   function automatic dest_t dest_of(input op_t op, input iclass_t cls,
                                     input logic dbit);
      dest_t dst;
      dst = DST_NONE;
      if (op inside {OP_MOVWF, OP_CLEAR_REGISTER_INSTR, OP_BCF, OP_BSF}) begin
         dst = DST_F;
      end else if (op inside {OP_CLRW, OP_MOVLW, OP_RETLW, OP_ADDLW,
            OP_SUBLW, OP_ANDLW, OP_IORLW, OP_XORLW}) begin
         dst = DST_W;
      end else if (cls == CLS_BYTE && op != OP_NOP) begin
         dst = dbit ? DST_F : DST_W;
      end
      return dst;
   endfunction

endpackage

// ---- instr_field_decode.sv ----
`timescale 1ns/1ps
module instr_field_decode
   import fourteen_bit_pkg::*;
(
   // Instruction word
   input wire logic [INSTR_W-1:0] instr_i,
   // Decoded operation and operand fields
   output iclass_t class_o,
   output op_t op_o,
   output logic [FADDR_W-1:0] faddr_o,
   output logic dbit_o,
   output logic [BIT_W-1:0] bitsel_o,
   output logic [LIT8_W-1:0] lit8_o,
   output logic [LIT11_W-1:0] lit11_o
);

   // Don't-care bits masked
   // Opcode match; '?' positions are ignored so don't-care bits never matter
   function automatic op_t decode_op(input logic [INSTR_W-1:0] iw);
      op_t op;
      op = OP_ILLEGAL;
      casez (iw)
         14'b00_0111_????_????: op = OP_ADDWF;
         14'b00_0101_????_????: op = OP_ANDWF;
         14'b00_0001_1???_????: op = OP_CLEAR_REGISTER_INSTR;
         14'b00_0001_0???_????: op = OP_CLRW;
         14'b00_1001_????_????: op = OP_COMF;
         14'b00_0011_????_????: op = OP_DECF;
         14'b00_1011_????_????: op = OP_DECFSZ;
         14'b00_1010_????_????: op = OP_INCF;
         14'b00_1111_????_????: op = OP_INCFSZ;
         14'b00_0100_????_????: op = OP_IORWF;
         14'b00_1000_????_????: op = OP_MOVF;
         14'b00_0000_1???_????: op = OP_MOVWF;
         14'b00_0000_0??0_0000: op = OP_NOP;
         14'b00_1101_????_????: op = OP_RLF;
         14'b00_1100_????_????: op = OP_RRF;
         14'b00_0010_????_????: op = OP_SUBWF;
         14'b00_1110_????_????: op = OP_SWAPF;
         14'b00_0110_????_????: op = OP_XORWF;
         14'b01_00??_????_????: op = OP_BCF;
         14'b01_01??_????_????: op = OP_BSF;
         14'b01_10??_????_????: op = OP_BTFSC;
         14'b01_11??_????_????: op = OP_BTFSS;
         14'b11_111?_????_????: op = OP_ADDLW;
         14'b11_1001_????_????: op = OP_ANDLW;
         14'b10_0???_????_????: op = OP_CALL;
         14'b00_0000_0110_0100: op = OP_CLRWDT;
         14'b10_1???_????_????: op = OP_GOTO;
         14'b11_1000_????_????: op = OP_IORLW;
         14'b11_00??_????_????: op = OP_MOVLW;
         14'b00_0000_0000_1001: op = OP_RETFIE;
         14'b11_01??_????_????: op = OP_RETLW;
         14'b00_0000_0000_1000: op = OP_RETURN;
         14'b00_0000_0110_0011: op = OP_SLEEP;
         14'b11_110?_????_????: op = OP_SUBLW;
         14'b11_1010_????_????: op = OP_XORLW;
         default: op = OP_ILLEGAL;
      endcase
      return op;
   endfunction

   // Three-way class split
   // Three classes; control words in the byte space count as control
   function automatic iclass_t class_of(input op_t op);
      iclass_t cls;
      cls = CLS_BYTE;
      if (op inside {OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS}) begin
         cls = CLS_BIT;
      end else if (op inside {OP_ADDLW, OP_ANDLW, OP_CALL, OP_CLRWDT,
            OP_GOTO, OP_IORLW, OP_MOVLW, OP_RETFIE, OP_RETLW, OP_RETURN,
            OP_SLEEP, OP_SUBLW, OP_XORLW, OP_ILLEGAL}) begin
         cls = CLS_LIT;
      end
      return cls;
   endfunction

   // Operation and class
   always_comb begin
      op_o = decode_op(instr_i);
      class_o = class_of(op_o);
   end

   // Operand fields, always extracted; the class decides which are used
   assign faddr_o = instr_i[F_LSB +: FADDR_W];
   assign dbit_o = instr_i[D_POS];
   assign bitsel_o = instr_i[B_LSB +: BIT_W];
   assign lit8_o = instr_i[K_LSB +: LIT8_W];
   assign lit11_o = instr_i[K_LSB +: LIT11_W];

endmodule

// ---- prog_mem.sv ----
`timescale 1ns/1ps
module prog_mem
   import fourteen_bit_pkg::*;
(
   // Clock
   input wire logic sys_clk_i,
   // Fetch address and returned word
   input wire logic [PC_W-1:0] addr_i,
   output logic [INSTR_W-1:0] word_o
);
   // Fixed test program; unused addresses read as no-operation
   function automatic logic [INSTR_W-1:0] rom(input logic [PC_W-1:0] a);
      case (a)
         13'h0000: rom = 14'h335A;
         13'h0001: rom = 14'h00A0; // Store accumulator to 0x20
         13'h0002: rom = 14'h0A20; // Increment 0x20 into accumulator
         13'h0003: rom = 14'h0186; // Clear second port register
         13'h0004: rom = 14'h1520; // Set bit 2 of 0x20
         13'h0005: rom = 14'h1D20; // Test bit 2, skip if set
         13'h0006: rom = 14'h30FF; // Must be skipped
         13'h0007: rom = 14'h280A; // Jump to 0x0A
         13'h0008: rom = 14'h30EE; // Prefetched, then discarded
         13'h000A: rom = 14'h03A0; // Decrement 0x20 in place
         13'h000B: rom = 14'h017F;
         13'h000C: rom = 14'h3E01; // Add literal one
         13'h000D: rom = 14'h0063; // Standby request
         13'h000E: rom = 14'h2010; // Call subroutine at 0x10
         13'h000F: rom = 14'h280F; // Park in a loop
         13'h0010: rom = 14'h0008; // Return to 0x0F
         default: rom = NOP_WORD;
      endcase
   endfunction

   initial word_o = NOP_WORD;

   always @(posedge sys_clk_i) begin
      #2 word_o <= rom(addr_i);
   end
endmodule

// ---- fourteen_bit_instruction_decode_tb.sv ----
`timescale 1ns/1ps
module fourteen_bit_instruction_decode_tb;
   import fourteen_bit_pkg::*;

   typedef struct packed {
      logic nop;
      logic rd;
      logic prd;
      logic wr;
      logic slp;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] w;
      logic z;
      logic [PC_W-1:0] pa;
   } row_t;

   logic sys_clk_i;
   logic nrst_i;
   logic [PC_W-1:0] prog_addr_o;
   logic [INSTR_W-1:0] instr_i;
   logic [FADDR_W-1:0] file_addr_o;
   logic file_rd_o;
   logic [DATA_W-1:0] file_rdata_i;
   logic file_wr_o;
   logic [DATA_W-1:0] file_wdata_o;
   logic second_io_port_rd_o;
   logic [DATA_W-1:0] w_o;
   logic zero_o;
   logic [PHASE_W-1:0] phase_o;
   logic cycle_start_o;
   logic nop_cycle_o;
   logic sleep_o;
   logic [DATA_W-1:0] regs [128];
   row_t rows [20];
   int mismatches;
   int checked;
   int cycles;

   fourteen_bit_instruction_decode dut (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .prog_addr_o(prog_addr_o), .instr_i(instr_i),
      .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
      .file_rdata_i(file_rdata_i), .file_wr_o(file_wr_o),
      .file_wdata_o(file_wdata_o),
      .second_io_port_rd_o(second_io_port_rd_o),
      .w_o(w_o), .carry_o(), .digit_carry_o(), .zero_o(zero_o),
      .phase_o(phase_o), .cycle_start_o(cycle_start_o),
      .nop_cycle_o(nop_cycle_o), .clrwdt_o(), .sleep_o(sleep_o),
      .retfie_o(), .illegal_o()
   );

   prog_mem pmem (
      .sys_clk_i(sys_clk_i), .addr_i(prog_addr_o), .word_o(instr_i)
   );

   // 20 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   // File register model; shows inverted data when not read
   always @(posedge sys_clk_i) begin
      if (file_wr_o) regs[file_addr_o] <= file_wdata_o;
      #2 file_rdata_i <= file_rd_o ? regs[file_addr_o] : ~regs[file_addr_o];
   end

   // Hang guard, well above the ~100 cycles the run needs
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 400) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Sample point: settled, same offset as every drive
   task automatic tick();
      @(posedge sys_clk_i);
      #2;
   endtask

   // One row per instruction cycle, entered at the phase 0 sample point
   task automatic run_rows(input int n);
      row_t r;
      for (int i = 0; i < n; i++) begin
         r = rows[i];
         check(phase_o, PH_Q1);
         check(cycle_start_o, 1'b1);
         check(nop_cycle_o, r.nop);
         check(prog_addr_o, r.pa);
         tick();
         check(file_rd_o, r.rd);
         check(second_io_port_rd_o, r.prd);
         tick();
         tick();
         check(file_wr_o, r.wr);
         if (r.wr) check(file_wdata_o, r.wdata);
         check(sleep_o, r.slp);
         tick();
         check(w_o, r.w);
         check(zero_o, r.z);
         $display("cycle %0d done", i);
      end
   endtask

   initial begin
      nrst_i = 1'b0;
      mismatches = 0;
      checked = 0;
      cycles = 0;
      file_rdata_i = 8'h00;
      for (int a = 0; a < 128; a++) regs[a] = 8'h00;
      regs[6] = 8'h33;
      // Expected flow: flush, program, skip, jump and call bubbles
      rows[0] = '{1, 0, 0, 0, 0, 8'h00, 8'h00, 0, 13'h0000};
      rows[1] = '{0, 0, 0, 0, 0, 8'h00, 8'h5A, 0, 13'h0001};
      rows[2] = '{0, 1, 0, 1, 0, 8'h5A, 8'h5A, 0, 13'h0002};
      rows[3] = '{0, 1, 0, 0, 0, 8'h00, 8'h5B, 0, 13'h0003};
      rows[4] = '{0, 1, 1, 1, 0, 8'h00, 8'h5B, 1, 13'h0004};
      rows[5] = '{0, 1, 0, 1, 0, 8'h5E, 8'h5B, 1, 13'h0005};
      rows[6] = '{0, 1, 0, 0, 0, 8'h00, 8'h5B, 1, 13'h0006};
      rows[7] = '{1, 0, 0, 0, 0, 8'h00, 8'h5B, 1, 13'h0007};
      rows[8] = '{0, 0, 0, 0, 0, 8'h00, 8'h5B, 1, 13'h0008};
      rows[9] = '{1, 0, 0, 0, 0, 8'h00, 8'h5B, 1, 13'h000A};
      rows[10] = '{0, 1, 0, 1, 0, 8'h5D, 8'h5B, 0, 13'h000B};
      rows[11] = '{0, 0, 0, 0, 0, 8'h00, 8'h00, 1, 13'h000C};
      rows[12] = '{0, 0, 0, 0, 0, 8'h00, 8'h01, 0, 13'h000D};
      rows[13] = '{0, 0, 0, 0, 1, 8'h00, 8'h01, 0, 13'h000E};
      rows[14] = '{0, 0, 0, 0, 0, 8'h00, 8'h01, 0, 13'h000F};
      rows[15] = '{1, 0, 0, 0, 0, 8'h00, 8'h01, 0, 13'h0010};
      rows[16] = '{0, 0, 0, 0, 0, 8'h00, 8'h01, 0, 13'h0011};
      rows[17] = '{1, 0, 0, 0, 0, 8'h00, 8'h01, 0, 13'h000F};
      rows[18] = '{0, 0, 0, 0, 0, 8'h00, 8'h01, 0, 13'h0010};
      rows[19] = '{1, 0, 0, 0, 0, 8'h00, 8'h01, 0, 13'h000F};
      repeat (2) tick();
      nrst_i = 1'b1;
      run_rows(20);
      // Reset in mid-run: state cleared, strobes quiet
      nrst_i = 1'b0;
      tick();
      tick();
      check(phase_o, PH_Q1);
      check(prog_addr_o, PC_RESET);
      check(nop_cycle_o, 1'b1);
      check(w_o, DATA_ZERO);
      check(file_rd_o, 1'b0);
      check(file_wr_o, 1'b0);
      $display("mid-run reset done");
      // Restart runs the program from address zero again
      nrst_i = 1'b1;
      run_rows(3);
      give_verdict();
   end
endmodule
